// ===== acs_sequencer.sv
// command-driven sequencer for the two auxiliary measurement paths
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int unsigned SOAK_SHORT_STEP = SOAK_SHORT_CYC,
    parameter int unsigned SOAK_LONG_STEP  = SOAK_LONG_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic                        hready,
    input  wire logic [31:0]                 hwdata,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic [NUM_PATHS-1:0]        adc_done,
    input  wire logic [NUM_PATHS-1:0][RES_W-1:0] adc_data,
    output acs_path_out_t [NUM_PATHS-1:0]    path_out
);

    typedef struct packed {
        acs_path_state_t       st;
        logic [4:0]            code;
        logic                  all_mode;
        logic                  ow;
        logic                  pull;
        logic [SOAK_CNT_W-1:0] soak_cnt;
        logic [RES_W-1:0]      res;
        acs_path_out_t         out;
    } acs_path_t;

    typedef struct packed {
        logic                    bus_pend;
        logic                    bus_rd;
        logic                    bus_wr;
        logic                    bus_map;
        logic [ADDR_MAP_W-1:0]   bus_addr;
        logic                    hreadyout;
        logic [31:0]             hrdata;
        logic                    soak_en;
        logic                    soak_range;
        logic [SOAK_VALUE_W-1:0] soak_value;
        logic [CMD_CNT_W-1:0]    cmd_cnt;
        acs_path_t [NUM_PATHS-1:0] path;
        acs_mem_wr_t             mem_wr;
    } acs_state_t;

    acs_state_t q;
    acs_state_t next_q;

    default clocking chk_clk @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic [RES_W-1:0]     mem_rd;
    logic [NUM_PATHS-1:0] go;
    logic [4:0]           go_sel [NUM_PATHS];
    logic [CMD_W-1:0]     cmd;
    logic                 cmd_wr;
    logic [SOAK_CNT_W-1:0] soak_load;

    // legal selection codes
    // legal selection for a path; the second path has no internal sources
    function automatic logic sel_ok(input logic second, input logic [4:0] s);
        sel_ok = (s <= SEL_GPIO_LAST) ||
                 (!second && s >= SEL_SECOND_REFERENCE && s <= SEL_RESISTOR_REF_SENSE);
    endfunction

    // next code of a round robin, zero once the last input is done
    function automatic logic [4:0] next_sel(input logic second, input logic [4:0] s);
        if (s == SEL_GPIO_LAST) begin
            next_sel = second ? SEL_ALL : SEL_SECOND_REFERENCE;
        end else if (s == SEL_RESISTOR_REF_SENSE) begin
            next_sel = SEL_ALL;
        end else begin
            next_sel = s + 5'h01;
        end
    endfunction

    acs_result_mem u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr      (q.mem_wr),
        .rd_addr (q.bus_addr[MEM_AW+1:2]),
        .rd_data (mem_rd)
    );

    // command decode from a register write in its data phase
    always_comb begin
        cmd    = hwdata[CMD_W-1:0];
        cmd_wr = q.bus_pend && q.bus_wr && q.bus_map && (q.bus_addr == OFS_CMD);
        go_sel[0] = {cmd[BIT_SEL4], cmd[3:0]};
        go[0] = cmd_wr && ((cmd & MAIN_MASK) == MAIN_VALUE) && sel_ok(1'b0, go_sel[0]);
        go_sel[1] = {1'b0, cmd[3:0]};
        // second path limited to general inputs
        go[1] = cmd_wr && ((cmd & SEC_MASK) == SEC_VALUE) && sel_ok(1'b1, go_sel[1]);
    end

    always_comb begin
        soak_load = '0;
        if (q.soak_en) begin
            if (q.soak_range) begin
                soak_load = SOAK_CNT_W'(q.soak_value * SOAK_LONG_STEP);
            end else begin
                soak_load = SOAK_CNT_W'(q.soak_value * SOAK_SHORT_STEP);
            end
        end
    end

    always_comb begin
        next_q = q;
        next_q.mem_wr.we = 1'b0;

        // bus slave: address phase, then one cycle for writes, two for reads
        if (q.bus_pend) begin
            next_q.bus_pend = 1'b0;
            if (q.bus_wr) begin
                if (q.bus_map && q.bus_addr == OFS_CONFIG) begin
                    next_q.soak_en    = hwdata[CFG_SOAK_EN_BIT];
                    next_q.soak_range = hwdata[CFG_RANGE_BIT];
                    next_q.soak_value = hwdata[CFG_VALUE_LSB +: SOAK_VALUE_W];
                end
                next_q.hreadyout = 1'b1;
            end else begin
                next_q.bus_rd = 1'b1;
            end
        end else if (q.bus_rd) begin
            next_q.bus_rd    = 1'b0;
            next_q.hreadyout = 1'b1;
            next_q.hrdata    = '0;
            if (q.bus_map && q.bus_addr[ADDR_MAP_W-1]) begin
                next_q.hrdata[RES_W-1:0] = mem_rd;
            end else if (q.bus_map && q.bus_addr == OFS_CONFIG) begin
                next_q.hrdata[CFG_SOAK_EN_BIT] = q.soak_en;
                next_q.hrdata[CFG_RANGE_BIT]   = q.soak_range;
                next_q.hrdata[CFG_VALUE_LSB +: SOAK_VALUE_W] = q.soak_value;
            end else if (q.bus_map && q.bus_addr == OFS_STATUS) begin
                next_q.hrdata[STS_BUSY_LSB]     = q.path[0].st != ST_IDLE;
                next_q.hrdata[STS_BUSY_LSB + 1] = q.path[1].st != ST_IDLE;
                next_q.hrdata[STS_CMD_CNT_LSB +: CMD_CNT_W] = q.cmd_cnt;
                next_q.hrdata[STS_MAIN_SEL_LSB +: 5] = q.path[0].code;
                next_q.hrdata[STS_SEC_SEL_LSB +: 5]  = q.path[1].code;
            end
        end else if (hsel && htrans[1] && hready) begin
            next_q.bus_pend  = 1'b1;
            next_q.bus_wr    = hwrite;
            next_q.bus_map   = haddr[31:ADDR_MAP_W] == '0;
            next_q.bus_addr  = haddr[ADDR_MAP_W-1:0];
            next_q.hreadyout = 1'b0;
        end

        if (go[0] || go[1]) begin
            next_q.cmd_cnt = q.cmd_cnt + CMD_CNT_W'(1);
        end

        // each path runs its own sequence
        for (int p = 0; p < NUM_PATHS; p++) begin
            next_q.path[p].out.adc_start = 1'b0;
            unique case (q.path[p].st)
                ST_IDLE: begin
                end
                ST_SETUP: begin
                    next_q.path[p].out.mux_sel = q.path[p].code;
                    // sources on with the mux, before soak
                    next_q.path[p].out.cs_on   = q.path[p].ow;
                    next_q.path[p].out.pull_up = q.path[p].pull;
                    next_q.path[p].soak_cnt    = soak_load;
                    next_q.path[p].st          = ST_SOAK;
                end
                ST_SOAK: begin
                    if (q.path[p].soak_cnt == '0) begin
                        next_q.path[p].out.adc_start = 1'b1;
                        next_q.path[p].st            = ST_CONV;
                    end else begin
                        next_q.path[p].soak_cnt = q.path[p].soak_cnt - SOAK_CNT_W'(1);
                    end
                end
                ST_CONV: begin
                    if (adc_done[p]) begin
                        // word kept per path so two paths finishing close together never mix
                        next_q.path[p].res = adc_data[p];
                        next_q.path[p].st  = ST_STORE;
                    end
                end
                ST_STORE: begin
                    // main path owns the write port when both finish together
                    if (p == 0 || q.path[0].st != ST_STORE) begin
                        // same result location with or without open wire
                        next_q.mem_wr.we   = 1'b1;
                        next_q.mem_wr.addr = {p[0], q.path[p].code};
                        next_q.mem_wr.data = q.path[p].res;
                        // round robin continues through all inputs
                        if (q.path[p].all_mode && next_sel(p[0], q.path[p].code) != SEL_ALL) begin
                            // ascending order, reserved code never visited
                            next_q.path[p].code = next_sel(p[0], q.path[p].code);
                            next_q.path[p].st   = ST_SETUP;
                        end else begin
                            next_q.path[p].st       = ST_IDLE;
                            next_q.path[p].out.cs_on = 1'b0;
                        end
                    end
                end
            endcase
            // restart on a new command; results untouched
            if (go[p]) begin
                next_q.path[p].st        = ST_SETUP;
                next_q.path[p].all_mode  = go_sel[p] == SEL_ALL;
                next_q.path[p].code      = (go_sel[p] == SEL_ALL) ? SEL_GPIO_FIRST : go_sel[p];
                // open wire only on the main path
                next_q.path[p].ow        = (p == 0) && cmd[BIT_OPEN_WIRE];
                next_q.path[p].pull      = (p == 0) && cmd[BIT_PULL];
                next_q.path[p].out.cs_on = 1'b0;
            end
        end
    end

    // bus idles ready so the first address phase after reset is taken at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q           <= '0;
            q.hreadyout <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign hrdata    = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp     = 1'b0;
    assign path_out  = {q.path[1].out, q.path[0].out};

    // helper views for the checks below
    acs_path_state_t       st0;
    logic [4:0]            code0;
    logic [SOAK_CNT_W-1:0] cnt0;
    logic [CMD_CNT_W-1:0]  cnt_cmd;
    acs_path_state_t       st1;
    logic [4:0]            code1;
    assign st0     = q.path[0].st;
    assign code0   = q.path[0].code;
    assign cnt0    = q.path[0].soak_cnt;
    assign cnt_cmd = q.cmd_cnt;
    assign st1     = q.path[1].st;
    assign code1   = q.path[1].code;

    chk_cmd_count: assert property (@(posedge clk_sys) disable iff (rst)
        (go[0] || go[1]) |=> cnt_cmd == $past(cnt_cmd) + CMD_CNT_W'(1))
        else $error("command counter did not step");

    chk_second_gpio: assert property (@(posedge clk_sys) disable iff (rst)
        path_out[1].mux_sel <= SEL_GPIO_LAST && !path_out[1].cs_on)
        else $error("second path left the general inputs");

    chk_restart_main: assert property (@(posedge clk_sys) disable iff (rst)
        go[0] |=> st0 == ST_SETUP ##1 path_out[0].mux_sel == code0)
        else $error("main path did not restart");

    chk_restart_second: assert property (@(posedge clk_sys) disable iff (rst)
        (go[1] && !go[0] && st0 == ST_IDLE) |=> q.path[1].st == ST_SETUP && st0 == ST_IDLE)
        else $error("second command disturbed the main path");

    chk_cs_at_mux: assert property (@(posedge clk_sys) disable iff (rst)
        (st0 == ST_SETUP && q.path[0].ow && !go[0]) |=> path_out[0].cs_on && st0 == ST_SOAK)
        else $error("current sources late");

    chk_pull_dir: assert property (@(posedge clk_sys) disable iff (rst)
        path_out[0].cs_on |-> path_out[0].pull_up == q.path[0].pull)
        else $error("pull direction mismatch");

    chk_soak_delay: assert property (@(posedge clk_sys) disable iff (rst)
        path_out[0].adc_start |-> $past(st0) == ST_SOAK && $past(cnt0) == '0)
        else $error("conversion started before soak end");

    chk_all_order: assert property (@(posedge clk_sys) disable iff (rst)
        (st0 == ST_STORE && !go[0] && q.path[0].all_mode && code0 != SEL_RESISTOR_REF_SENSE)
        |=> st0 == ST_SETUP && code0 != SEL_RESERVED &&
            (code0 == $past(code0) + 5'h01 || code0 == SEL_SECOND_REFERENCE))
        else $error("round robin order broken");

    chk_result_store: assert property (@(posedge clk_sys) disable iff (rst)
        (st0 == ST_CONV && adc_done[0] && !go[0]) ##1 !go[0]
        |=> q.mem_wr.we && q.mem_wr.addr == {1'b0, $past(code0, 2)} &&
            q.mem_wr.data == $past(adc_data[0], 2))
        else $error("result not stored at its channel");

    chk_cmd_hold: assert property (
        !(go[0] || go[1]) |=> cnt_cmd == $past(cnt_cmd))
        else $error("counter moved without a command");

    chk_start_code: assert property (
        path_out[0].adc_start |-> path_out[0].mux_sel != SEL_RESERVED && path_out[0].mux_sel != SEL_ALL)
        else $error("conversion on an illegal code");

    chk_restart_sec: assert property (
        go[1] |=> st1 == ST_SETUP ##1 path_out[1].mux_sel == code1)
        else $error("second path did not restart");

    chk_sec_last: assert property (
        (st1 == ST_STORE && st0 != ST_STORE && code1 == SEL_GPIO_LAST && !go[1])
        |=> st1 == ST_IDLE)
        else $error("second cycle ran past its last input");

    chk_idle_sources: assert property (
        st0 == ST_IDLE |-> !path_out[0].cs_on)
        else $error("sources on while idle");

    chk_cycle_sources: assert property (
        (st0 == ST_STORE && q.path[0].all_mode && q.path[0].ow && !go[0] && code0 != SEL_RESISTOR_REF_SENSE)
        |=> path_out[0].cs_on)
        else $error("sources dropped between inputs");

endmodule

// ===== acs_pkg.sv
// shared constants and carrier types for the auxiliary conversion sequencer
package acs_pkg;

    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    // register byte offsets (low nine address bits)
    localparam logic [8:0] OFS_CMD    = 9'h000;
    localparam logic [8:0] OFS_CONFIG = 9'h004;
    localparam logic [8:0] OFS_STATUS = 9'h008;
    localparam int unsigned ADDR_MAP_W = 9;

    // command code field
    localparam int unsigned CMD_W      = 11;
    localparam logic [10:0] MAIN_MASK  = 11'h630;
    localparam logic [10:0] MAIN_VALUE = 11'h410;
    localparam logic [10:0] SEC_MASK   = 11'h7f0;
    localparam logic [10:0] SEC_VALUE  = 11'h400;
    localparam int unsigned BIT_OPEN_WIRE = 8;
    localparam int unsigned BIT_PULL      = 7;
    localparam int unsigned BIT_SEL4      = 6;

    // input selection codes
    localparam logic [4:0] SEL_ALL                   = 5'h00;
    localparam logic [4:0] SEL_GPIO_FIRST            = 5'h01;
    localparam logic [4:0] SEL_GPIO_LAST             = 5'h09;
    localparam logic [4:0] SEL_SECOND_REFERENCE      = 5'h10;
    localparam logic [4:0] SEL_DIGITAL_SUPPLY_SENSE  = 5'h11;
    localparam logic [4:0] SEL_ANALOG_SUPPLY_SENSE   = 5'h12;
    localparam logic [4:0] SEL_DIE_TEMPERATURE       = 5'h13;
    localparam logic [4:0] SEL_POSITIVE_SUPPLY_SENSE = 5'h14;
    localparam logic [4:0] SEL_NEGATIVE_SUPPLY_SENSE = 5'h15;
    localparam logic [4:0] SEL_RESISTOR_REF_SENSE    = 5'h16;
    localparam logic [4:0] SEL_RESERVED              = 5'h17;

    // configuration register fields
    localparam int unsigned CFG_SOAK_EN_BIT   = 0;
    localparam int unsigned CFG_RANGE_BIT     = 1;
    localparam int unsigned CFG_VALUE_LSB     = 4;
    localparam int unsigned SOAK_VALUE_W      = 4;

    // status register fields
    localparam int unsigned STS_BUSY_LSB      = 0;
    localparam int unsigned STS_CMD_CNT_LSB   = 8;
    localparam int unsigned STS_MAIN_SEL_LSB  = 16;
    localparam int unsigned STS_SEC_SEL_LSB   = 24;

    // soak step lengths per range and their cycle counts
    localparam int unsigned SOAK_SHORT_NS  = 20_000;
    localparam int unsigned SOAK_LONG_NS   = 640_000;
    localparam int unsigned SOAK_SHORT_CYC = SOAK_SHORT_NS / CLK_PERIOD_NS;
    localparam int unsigned SOAK_LONG_CYC  = SOAK_LONG_NS / CLK_PERIOD_NS;
    localparam int unsigned SOAK_CNT_W     = 20;

    localparam int unsigned CMD_CNT_W  = 8;
    localparam int unsigned RES_W      = 16;
    localparam int unsigned MEM_AW     = 6;
    localparam int unsigned NUM_PATHS  = 2;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_SOAK, ST_CONV, ST_STORE} acs_path_state_t;

    typedef struct packed {
        logic [4:0] mux_sel;
        logic       cs_on;
        logic       pull_up;
        logic       adc_start;
    } acs_path_out_t;

    typedef struct packed {
        logic              we;
        logic [MEM_AW-1:0] addr;
        logic [RES_W-1:0]  data;
    } acs_mem_wr_t;

endpackage

// ===== acs_result_mem.sv
// result storage for both measurement paths, registered read port
module acs_result_mem
    import acs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire acs_mem_wr_t       wr,
    input  wire logic [MEM_AW-1:0] rd_addr,
    output logic      [RES_W-1:0]  rd_data
);

    localparam int unsigned DEPTH = 2 ** MEM_AW;

    logic [RES_W-1:0] mem [DEPTH];

    // reset to zero so unwritten channels read a defined value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            if (wr.we) begin
                mem[wr.addr] <= wr.data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ===== acs_adc_model.sv
// behavioural converter pair standing on the far side of both paths
module acs_adc_model
    import acs_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire acs_path_out_t [NUM_PATHS-1:0] path_out,
    input  wire logic                          slow,
    input  wire logic [6:0]                    data_tag,
    output logic [NUM_PATHS-1:0]               adc_done,
    output logic [NUM_PATHS-1:0][RES_W-1:0]    adc_data
);
    timeunit 1ns;
    timeprecision 1ps;

    int         cnt [NUM_PATHS];
    logic [4:0] sel [NUM_PATHS];

    always_ff @(posedge clk_sys or posedge rst) begin
        for (int p = 0; p < NUM_PATHS; p++) begin
            if (rst) begin
                cnt[p]      <= 0;
                sel[p]      <= 5'h00;
                adc_done[p] <= 1'b0;
                adc_data[p] <= '0;
            end else begin
                adc_done[p] <= 1'b0;
                // a new start pulse restarts the countdown
                if (path_out[p].adc_start) begin
                    cnt[p] <= slow ? 40 : 3;
                    sel[p] <= path_out[p].mux_sel;
                end else if (cnt[p] > 0) begin
                    cnt[p] <= cnt[p] - 1;
                end
                if (cnt[p] == 1 && !path_out[p].adc_start) begin
                    adc_done[p] <= 1'b1;
                    adc_data[p] <= {data_tag, p[0], 3'b000, sel[p]};
                end else begin
                    // idle word keeps toggling so a stale value is never taken for a result
                    adc_data[p] <= ~adc_data[p];
                end
            end
        end
    end
endmodule

// ===== testbench.sv
// self-checking bench for the auxiliary conversion sequencer
module testbench
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BOUND = 2000;
    logic                            clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, slow;
    logic [31:0]                     haddr, hwdata, hrdata;
    logic [1:0]                      htrans;
    logic [2:0]                      hsize;
    logic [6:0]                      data_tag;
    logic [7:0]                      exp_cnt;
    logic [NUM_PATHS-1:0]            adc_done;
    logic [NUM_PATHS-1:0][RES_W-1:0] adc_data;
    acs_path_out_t [NUM_PATHS-1:0]   path_out;
    int                              mismatches, cmp_count;

    assign hready = hreadyout;

    acs_sequencer #(.SOAK_SHORT_STEP(2), .SOAK_LONG_STEP(5)) u_acs_sequencer (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .adc_done(adc_done), .adc_data(adc_data), .path_out(path_out));

    acs_adc_model u_acs_adc_model (
        .clk_sys(clk_sys), .rst(rst), .path_out(path_out), .slow(slow), .data_tag(data_tag),
        .adc_done(adc_done), .adc_data(adc_data));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < BOUND);
        if (n >= BOUND) begin
            mismatches++;
            $display("BAD hready expected 1 seen 0");
            tally_and_finish();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_check(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask

    function automatic logic [10:0] main_cmd(input logic ow, input logic pu, input logic [4:0] c);
        return {2'b10, ow, pu, c[4], 2'b01, c[3:0]};
    endfunction

    function automatic logic [4:0] code_of(input int i);
        return (i < 9) ? 5'(i + 1) : 5'(i + 7);
    endfunction

    function automatic logic [31:0] res_addr(input int p, input logic [4:0] c);
        return 32'h100 + 32'(p) * 32'h80 + 32'(c) * 32'h4;
    endfunction

    function automatic logic [31:0] res_val(input int p, input logic [4:0] c);
        return {16'h0, data_tag, p[0], 3'b000, c};
    endfunction

    task automatic wait_start(input int p, input int bound, output logic hit);
        hit = 1'b0;
        for (int n = 0; n < bound && !hit; n++) begin
            @(posedge clk_sys);
            hit = (path_out[p].adc_start === 1'b1);
        end
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            ahb(1'b0, 32'(OFS_STATUS), 32'h0, q);
            n++;
        end while (q[1:0] !== 2'b00 && n < 200);
        check("busy", 32'h0, {30'h0, q[1:0]});
        ahb(1'b0, 32'(OFS_STATUS), 32'h0, q);
        check("command counter", 32'(exp_cnt), 32'(q[15:8]));
    endtask

    task automatic convert_one(input int p, input logic [10:0] cmd, input logic [4:0] c);
        logic hit;
        wr(32'(OFS_CMD), 32'(cmd));
        exp_cnt++;
        wait_start(p, BOUND, hit);
        check("start", 32'h1, 32'(hit));
        check("mux select", 32'(c), 32'(path_out[p].mux_sel));
        wait_idle();
        rd_check("result", res_addr(p, c), res_val(p, c));
    endtask

    task automatic test_reset();
        rd_check("status at reset", 32'(OFS_STATUS), 32'h0);
        rd_check("result at reset", 32'h10c, 32'h0);
        wr(32'h00c, 32'hffff_ffff);
        rd_check("unmapped read", 32'h00c, 32'h0);
        rd_check("high address read", 32'h200, 32'h0);
        rd_check("command read", 32'(OFS_CMD), 32'h0);
        $display("test reset done");
    endtask

    task automatic test_decode();
        data_tag = 7'h15;
        for (int i = 0; i < 16; i++) convert_one(0, main_cmd(1'b0, 1'b0, code_of(i)), code_of(i));
        for (int i = 0; i < 9; i++) convert_one(1, {7'h40, 4'(code_of(i))}, code_of(i));
        $display("test decode done");
    endtask

    task automatic test_refuse();
        logic [10:0] bad [5] = '{main_cmd(1'b0, 1'b0, 5'h17), main_cmd(1'b0, 1'b0, 5'h0a), 11'h40a,
                                 11'h000, 11'h4c3};
        logic hit;
        foreach (bad[k]) begin
            wr(32'(OFS_CMD), 32'(bad[k]));
            for (int p = 0; p < 2; p++) begin
                wait_start(p, 30, hit);
                check("refused start", 32'h0, 32'(hit));
            end
            wait_idle();
        end
        $display("test refuse done");
    endtask

    task automatic test_soak();
        logic [31:0] cfg [2] = '{32'h31, 32'h33};
        int          nsoak [2] = '{6, 15};
        int          t0;
        logic        hit;
        data_tag = 7'h2a;
        for (int k = 0; k < 2; k++) begin
            wr(32'(OFS_CONFIG), cfg[k]);
            rd_check("config", 32'(OFS_CONFIG), cfg[k]);
            wr(32'(OFS_CMD), 32'(main_cmd(1'b1, 1'b1, 5'h02)));
            exp_cnt++;
            t0 = -1;
            hit = 1'b0;
            for (int n = 0; n < BOUND && !hit; n++) begin
                @(posedge clk_sys);
                if (t0 < 0 && path_out[0].cs_on === 1'b1) begin
                    t0 = n;
                    check("mux at sources on", 32'h2, 32'(path_out[0].mux_sel));
                    check("pull up", 32'h1, 32'(path_out[0].pull_up));
                end
                hit = (path_out[0].adc_start === 1'b1);
                if (hit) check("soak cycles", 32'(nsoak[k] + 1), 32'(n - t0));
            end
            check("sources during start", 32'h1, 32'(path_out[0].cs_on));
            wait_idle();
            rd_check("open wire result", res_addr(0, 5'h02), res_val(0, 5'h02));
        end
        wr(32'(OFS_CONFIG), 32'h0);
        $display("test soak done");
    endtask

    task automatic test_round_robin();
        logic hit;
        data_tag = 7'h61;
        wr(32'(OFS_CMD), 32'(main_cmd(1'b1, 1'b0, 5'h00)));
        exp_cnt++;
        for (int i = 0; i < 16; i++) begin
            wait_start(0, BOUND, hit);
            check("cycle select", 32'(code_of(i)), 32'(path_out[0].mux_sel));
            check("cycle sources", 32'h1, 32'(path_out[0].cs_on));
            check("cycle pull down", 32'h0, 32'(path_out[0].pull_up));
        end
        wait_start(0, 60, hit);
        check("cycle stops", 32'h0, 32'(hit));
        wait_idle();
        rd_check("last channel", res_addr(0, 5'h16), res_val(0, 5'h16));
        data_tag = 7'h0e;
        wr(32'(OFS_CMD), 32'h400);
        exp_cnt++;
        for (int i = 0; i < 9; i++) begin
            wait_start(1, BOUND, hit);
            check("second cycle select", 32'(code_of(i)), 32'(path_out[1].mux_sel));
        end
        wait_idle();
        rd_check("second ninth", res_addr(1, 5'h09), res_val(1, 5'h09));
        data_tag = 7'h61;
        rd_check("main untouched", res_addr(0, 5'h05), res_val(0, 5'h05));
        $display("test round robin done");
    endtask

    task automatic test_restart();
        logic hit;
        data_tag = 7'h33;
        convert_one(0, main_cmd(1'b0, 1'b0, 5'h04), 5'h04);
        slow = 1'b1;
        data_tag = 7'h44;
        wr(32'(OFS_CMD), 32'(main_cmd(1'b0, 1'b0, 5'h04)));
        wait_start(0, BOUND, hit);
        wr(32'(OFS_CMD), 32'(main_cmd(1'b0, 1'b0, 5'h05)));
        exp_cnt += 8'h2;
        wait_idle();
        rd_check("new result", res_addr(0, 5'h05), res_val(0, 5'h05));
        data_tag = 7'h33;
        rd_check("kept result", res_addr(0, 5'h04), res_val(0, 5'h04));
        slow = 1'b0;
        $display("test restart done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        slow = 1'b0;
        data_tag = 7'h00;
        exp_cnt = 8'h00;
        mismatches = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        test_reset();
        test_decode();
        test_refuse();
        test_soak();
        test_round_robin();
        test_restart();
        tally_and_finish();
    end
endmodule
